// *** hsi_top.sv ***
// Purpose: host port that selects SPI, UART or two-wire (pins released) after reset and turns serial
//          transfers into register reads and writes
// Assumes: SCK well below CLK_SYS/4; register reads answer on REG_RD_DATA
//          in the cycle after REG_RD_STROBE
// Notes: writes pass a FIFO; reads do not wait for it to drain
`timescale 1ns/1ps

module hsi_top
  import hsi_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic TWO_WIRE_SEL_PIN,
  input wire logic EXT_ADDR_SELECT_PIN,
  input wire logic SPI_SELECT_N,
  input wire logic D5_IN,
  output logic D5_OUT,
  output logic D5_OE,
  input wire logic D6_IN,
  output logic D6_OUT,
  output logic D6_OE,
  input wire logic D7_IN,
  output logic D7_OUT,
  output logic D7_OE,
  output logic [1:0] HOST_MODE,
  output logic REG_RD_STROBE,
  output logic [5:0] REG_RD_ADDR,
  input wire logic [7:0] REG_RD_DATA,
  output logic REG_WR_VALID,
  input wire logic REG_WR_READY,
  output logic [5:0] REG_WR_ADDR,
  output logic [7:0] REG_WR_DATA,
  output logic WR_OVERRUN
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sel_sync;
  logic [1:0] ea_sync;
  logic [1:0] nss_sync;
  logic [1:0] sck_sync;
  logic [1:0] mosi_sync;
  logic sck_prev;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sel_sync <= 2'h0;
      ea_sync <= 2'h0;
      nss_sync <= 2'h3;
      sck_sync <= 2'h0;
      mosi_sync <= 2'h0;
      sck_prev <= 1'b0;
    end else begin
      sel_sync <= {sel_sync[0], TWO_WIRE_SEL_PIN};
      ea_sync <= {ea_sync[0], EXT_ADDR_SELECT_PIN};
      nss_sync <= {nss_sync[0], SPI_SELECT_N};
      sck_sync <= {sck_sync[0], D5_IN};
      mosi_sync <= {mosi_sync[0], D6_IN};
      sck_prev <= sck_sync[1];
    end
  end

  logic spi_select_n;
  logic sck_rise;
  logic sck_fall;
  // the select pin doubles as the UART receive line
  assign spi_select_n = nss_sync[1];
  assign sck_rise = sck_sync[1] && !sck_prev;
  assign sck_fall = !sck_sync[1] && sck_prev;

  // ----------------------------------------------------------------
  // interface selection
  // ----------------------------------------------------------------
  hsi_mode_type mode;
  logic mode_done;
  logic [1:0] mode_wait;

  // waits for the synchronisers to fill before sampling
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      mode <= HSI_MODE_NONE;
      mode_done <= 1'b0;
      mode_wait <= 2'h0;
    end else if (!mode_done) begin
      if (mode_wait == 2'(MODE_WAIT_CYCLES)) begin
        mode_done <= 1'b1;
        if (sel_sync[1]) begin
          mode <= HSI_MODE_TWO_WIRE;
        end else if (ea_sync[1]) begin
          mode <= HSI_MODE_SPI;
        end else begin
          mode <= HSI_MODE_UART;
        end
      end else begin
        mode_wait <= mode_wait + 2'h1;
      end
    end
  end

  logic is_spi;
  logic is_uart;
  assign is_spi = (mode == HSI_MODE_SPI);
  assign is_uart = (mode == HSI_MODE_UART);

  // ----------------------------------------------------------------
  // SPI byte shifter
  // ----------------------------------------------------------------
  logic [7:0] spi_shift;
  logic [2:0] spi_bits;
  logic spi_byte_valid;
  logic [7:0] spi_byte;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      spi_shift <= 8'h00;
      spi_bits <= 3'h0;
      spi_byte_valid <= 1'b0;
      spi_byte <= 8'h00;
    end else begin
      spi_byte_valid <= 1'b0;
      if (!is_spi || spi_select_n) begin
        spi_bits <= 3'h0;
      end else if (sck_rise) begin
        spi_shift <= {spi_shift[6:0], mosi_sync[1]};
        spi_bits <= spi_bits + 3'h1;
        if (spi_bits == 3'h7) begin
          spi_byte_valid <= 1'b1;
          spi_byte <= {spi_shift[6:0], mosi_sync[1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // internal registers
  // ----------------------------------------------------------------
  logic [7:0] speed;
  logic line_en;
  logic wr_req;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      speed <= SPEED_RESET;
      line_en <= LINE_EN_RESET;
    end else if (wr_req) begin
      if (wr_addr == SPEED_ADDR) begin
        speed <= wr_data;
      end
      if (wr_addr == TEST_PIN_ADDR) begin
        line_en <= wr_data[LINE_EN_BIT];
      end
    end
  end

  function automatic logic [7:0] read_mux(input logic [5:0] a, input logic [7:0] ext,
                                          input logic [7:0] spd, input logic len);
    if (a == SPEED_ADDR) begin
      read_mux = spd;
    end else if (a == TEST_PIN_ADDR) begin
      read_mux = {len, 7'h00};
    end else begin
      read_mux = ext;
    end
  endfunction : read_mux

  // ----------------------------------------------------------------
  // UART
  // ----------------------------------------------------------------
  logic tx_start;
  logic [7:0] tx_data;
  logic tx_busy;
  logic tx_line;
  logic rx_valid;
  logic [7:0] rx_data;

  hsi_uart u_uart (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .speed(speed),
    .rx_in(spi_select_n),
    .tx_start(tx_start),
    .tx_data(tx_data),
    .tx_busy(tx_busy),
    .tx_line(tx_line),
    .rx_valid(rx_valid),
    .rx_data(rx_data)
  );

  // ----------------------------------------------------------------
  // transaction decoder
  // ----------------------------------------------------------------
  logic txn_first;
  logic txn_read;
  logic [5:0] txn_addr;
  logic uart_wait_data;
  logic rd_pending;
  logic rd_for_uart;
  logic miso_load;
  logic [7:0] miso_value;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      txn_first <= 1'b1;
      txn_read <= 1'b0;
      txn_addr <= 6'h00;
      uart_wait_data <= 1'b0;
      rd_pending <= 1'b0;
      rd_for_uart <= 1'b0;
      REG_RD_STROBE <= 1'b0;
      REG_RD_ADDR <= 6'h00;
      wr_req <= 1'b0;
      wr_addr <= 6'h00;
      wr_data <= 8'h00;
      tx_start <= 1'b0;
      tx_data <= 8'h00;
      miso_load <= 1'b0;
      miso_value <= 8'h00;
    end else begin
      REG_RD_STROBE <= 1'b0;
      wr_req <= 1'b0;
      tx_start <= 1'b0;
      miso_load <= 1'b0;
      rd_pending <= REG_RD_STROBE;
      if (rd_pending) begin
        if (rd_for_uart) begin
          tx_start <= 1'b1;
          tx_data <= read_mux(REG_RD_ADDR, REG_RD_DATA, speed, line_en);
        end else begin
          miso_load <= 1'b1;
          miso_value <= read_mux(REG_RD_ADDR, REG_RD_DATA, speed, line_en);
        end
      end
      if (is_spi && spi_select_n) begin
        txn_first <= 1'b1;
      end else if (is_spi && spi_byte_valid) begin
        txn_first <= 1'b0;
        if (txn_first) begin
          txn_read <= spi_byte[RW_BIT];
          txn_addr <= spi_byte[SPI_ADDR_MSB:SPI_ADDR_LSB];
          if (spi_byte[RW_BIT]) begin
            REG_RD_STROBE <= 1'b1;
            REG_RD_ADDR <= spi_byte[SPI_ADDR_MSB:SPI_ADDR_LSB];
            rd_for_uart <= 1'b0;
          end
        end else if (txn_read) begin
          if (spi_byte != SPI_END_BYTE) begin
            REG_RD_STROBE <= 1'b1;
            REG_RD_ADDR <= spi_byte[SPI_ADDR_MSB:SPI_ADDR_LSB];
            rd_for_uart <= 1'b0;
          end
        end else begin
          wr_req <= 1'b1; // same address for every byte
          wr_addr <= txn_addr;
          wr_data <= spi_byte;
        end
      end else if (is_uart && rx_valid) begin
        if (!uart_wait_data) begin
          if (rx_data[RW_BIT]) begin
            REG_RD_STROBE <= 1'b1;
            REG_RD_ADDR <= rx_data[UART_ADDR_MSB:UART_ADDR_LSB];
            rd_for_uart <= 1'b1;
          end else begin
            uart_wait_data <= 1'b1;
            txn_addr <= rx_data[UART_ADDR_MSB:UART_ADDR_LSB];
            tx_start <= 1'b1; // echo in the data slot
            tx_data <= rx_data;
          end
        end else begin
          uart_wait_data <= 1'b0;
          wr_req <= 1'b1;
          wr_addr <= txn_addr;
          wr_data <= rx_data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // MISO shifter: changes only on falling edges
  // ----------------------------------------------------------------
  logic [7:0] miso_shift;
  logic miso_bit;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      miso_shift <= 8'h00;
      miso_bit <= 1'b0;
    end else if (miso_load) begin
      miso_shift <= miso_value;
    end else if (is_spi && !spi_select_n && sck_fall) begin
      miso_bit <= miso_shift[7]; // msb first
      miso_shift <= {miso_shift[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // write FIFO and register write port
  // ----------------------------------------------------------------
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [13:0] fifo_out_data;

  // a serial master cannot be stalled, so a full FIFO drops and flags
  assign fifo_out_ready = !REG_WR_VALID || REG_WR_READY;

  hsi_fifo #(
    .WIDTH(ADDR_W + DATA_W),
    .DEPTH(WR_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .in_valid(wr_req),
    .in_ready(fifo_in_ready),
    .in_data({wr_addr, wr_data}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      REG_WR_VALID <= 1'b0;
      REG_WR_ADDR <= 6'h00;
      REG_WR_DATA <= 8'h00;
      WR_OVERRUN <= 1'b0;
    end else begin
      if (fifo_out_ready) begin
        REG_WR_VALID <= fifo_out_valid;
        if (fifo_out_valid) begin
          REG_WR_ADDR <= fifo_out_data[13:8];
          REG_WR_DATA <= fifo_out_data[7:0];
        end
      end
      if (wr_req && !fifo_in_ready) begin
        WR_OVERRUN <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      D5_OUT <= 1'b0;
      D5_OE <= 1'b0;
      D6_OUT <= 1'b1;
      D6_OE <= 1'b0;
      D7_OUT <= 1'b1;
      D7_OE <= 1'b0;
      HOST_MODE <= 2'h0;
    end else begin
      HOST_MODE <= mode;
      if (is_spi) begin
        D5_OUT <= 1'b0; // sck is an input only
        D5_OE <= 1'b0;
        D6_OUT <= 1'b0;
        D6_OE <= 1'b0;
        D7_OUT <= miso_bit;
        D7_OE <= !spi_select_n;
      end else if (is_uart) begin
        D5_OUT <= tx_busy;
        D5_OE <= line_en;
        D6_OUT <= tx_line;
        D6_OE <= line_en;
        D7_OUT <= tx_line;
        D7_OE <= 1'b1;
      end else begin
        D5_OUT <= 1'b0;
        D5_OE <= 1'b0;
        D6_OUT <= 1'b1;
        D6_OE <= 1'b0;
        D7_OUT <= 1'b1;
        D7_OE <= 1'b0;
      end
    end
  end

endmodule : hsi_top

// *** hsi_pkg.sv ***
// Purpose: shared constants and types of the host serial interface
// Assumes: CLK_SYS at 20 MHz; baud figures expressed against a 27.12 MHz device clock
// Notes: register addresses are six-bit register indices
package hsi_pkg;

  // ----------------------------------------------------------------
  // clocks
  // ----------------------------------------------------------------
  localparam int SYS_CLK_KHZ = 20000;
  localparam int DEV_CLK_KHZ = 27120;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int WR_FIFO_DEPTH = 8;
  localparam int MODE_WAIT_CYCLES = 3;

  // ----------------------------------------------------------------
  // internal registers
  // ----------------------------------------------------------------
  localparam logic [5:0] SPEED_ADDR = 6'h1F;
  localparam logic [5:0] TEST_PIN_ADDR = 6'h33;
  localparam int LINE_EN_BIT = 7;
  localparam logic [7:0] SPEED_RESET = 8'hEB;
  localparam logic LINE_EN_RESET = 1'b1;
  localparam int SPEED_EXP_MSB = 7;
  localparam int SPEED_EXP_LSB = 5;
  localparam int SPEED_MANT_MSB = 4;
  localparam int SPEED_MANT_LSB = 0;
  localparam int MANT_LOW_OFFSET = 1;
  localparam int MANT_HIGH_OFFSET = 33;

  // ----------------------------------------------------------------
  // address byte layouts
  // ----------------------------------------------------------------
  localparam int RW_BIT = 7;
  localparam int SPI_ADDR_MSB = 6;
  localparam int SPI_ADDR_LSB = 1;
  localparam int UART_ADDR_MSB = 5;
  localparam int UART_ADDR_LSB = 0;
  localparam logic [7:0] SPI_END_BYTE = 8'h00;
  localparam int UART_FRAME_BITS = 9;

  typedef enum logic [1:0] {
    HSI_MODE_NONE = 2'b00,
    HSI_MODE_UART = 2'b01,
    HSI_MODE_SPI = 2'b10,
    HSI_MODE_TWO_WIRE = 2'b11
  } hsi_mode_type;

  // divisor in device clock periods per bit
  function automatic logic [12:0] baud_divisor(input logic [7:0] speed);
    logic [2:0] ex;
    logic [12:0] mant;
    ex = speed[SPEED_EXP_MSB:SPEED_EXP_LSB];
    mant = {8'h00, speed[SPEED_MANT_MSB:SPEED_MANT_LSB]};
    if (ex == 3'h0) begin
      baud_divisor = mant + 13'(MANT_LOW_OFFSET);
    end else begin
      baud_divisor = 13'((mant + 13'(MANT_HIGH_OFFSET)) << (ex - 3'h1));
    end
  endfunction : baud_divisor

endpackage : hsi_pkg

// *** hsi_fifo.sv ***
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: out_data is read from storage by index
`timescale 1ns/1ps
module hsi_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : hsi_fifo

// *** hsi_uart.sv ***
// Purpose: 8N1 transmitter and receiver with programmable rate
// Assumes: rx_in already synchronised to clk
// Notes: rate tracks a 27.12 MHz reference by fractional accumulation
`timescale 1ns/1ps
module hsi_uart
  import hsi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] speed,
  input wire logic rx_in,
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  output logic tx_busy,
  output logic tx_line,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  logic [31:0] threshold;
  logic [31:0] tx_acc;
  logic [31:0] rx_acc;
  logic [8:0] tx_frame;
  logic [3:0] tx_cnt;
  logic [3:0] rx_cnt;
  logic rx_busy;
  logic tx_tick;
  logic rx_tick;

  // average error zero against the reference; jitter of one system clock per bit
  assign threshold = 32'(baud_divisor(speed)) * 32'(SYS_CLK_KHZ);
  assign tx_tick = (tx_acc + 32'(DEV_CLK_KHZ)) >= threshold;
  assign rx_tick = (rx_acc + 32'(DEV_CLK_KHZ)) >= threshold;

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_line <= 1'b1;
      tx_frame <= '1;
      tx_cnt <= '0;
      tx_acc <= '0;
    end else if (tx_start && !tx_busy) begin
      tx_frame <= {1'b1, tx_data}; // lsb first, stop last
      tx_line <= 1'b0;
      tx_cnt <= '0;
      tx_acc <= '0;
      tx_busy <= 1'b1;
    end else if (tx_busy) begin
      if (tx_tick) begin
        tx_acc <= tx_acc + 32'(DEV_CLK_KHZ) - threshold;
        if (tx_cnt == 4'(UART_FRAME_BITS)) begin
          tx_busy <= 1'b0;
        end else begin
          tx_line <= tx_frame[0];
          tx_frame <= {1'b1, tx_frame[8:1]};
          tx_cnt <= tx_cnt + 4'h1;
        end
      end else begin
        tx_acc <= tx_acc + 32'(DEV_CLK_KHZ);
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver: sample in mid bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy <= 1'b0;
      rx_cnt <= '0;
      rx_acc <= '0;
      rx_data <= '0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_busy) begin
        if (!rx_in) begin
          rx_busy <= 1'b1;
          rx_cnt <= '0;
          rx_acc <= threshold >> 1;
        end
      end else if (rx_tick) begin
        rx_acc <= rx_acc + 32'(DEV_CLK_KHZ) - threshold;
        rx_cnt <= rx_cnt + 4'h1;
        if (rx_cnt == 4'h0 && rx_in) begin
          rx_busy <= 1'b0; // glitch, not a start bit
        end else if (rx_cnt == 4'(UART_FRAME_BITS)) begin
          rx_busy <= 1'b0;
          rx_valid <= rx_in; // stop bit must be one, no parity
        end else if (rx_cnt != 4'h0) begin
          rx_data <= {rx_in, rx_data[7:1]};
        end
      end else begin
        rx_acc <= rx_acc + 32'(DEV_CLK_KHZ);
      end
    end
  end

endmodule : hsi_uart

// *** hsi_top_asserts.sv ***
// Purpose: port checks of hsi_top
// Assumes: host keeps SCK phases of 6 CLK_SYS
// Notes: bound to every hsi_top instance
`timescale 1ns/1ps
module hsi_top_asserts
  import hsi_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic TWO_WIRE_SEL_PIN,
  input wire logic EXT_ADDR_SELECT_PIN,
  input wire logic SPI_SELECT_N,
  input wire logic D5_IN,
  input wire logic D5_OE,
  input wire logic D6_OE,
  input wire logic D7_OUT,
  input wire logic D7_OE,
  input wire logic [1:0] HOST_MODE,
  input wire logic REG_WR_VALID,
  input wire logic REG_WR_READY,
  input wire logic [5:0] REG_WR_ADDR,
  input wire logic [7:0] REG_WR_DATA
);
  // ------
  // checks
  // ------
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  logic [3:0] since_rst;
  // saturates so the timing check fires once per reset
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      since_rst <= 4'h0;
    end else if (since_rst != 4'hF) begin
      since_rst <= since_rst + 4'h1;
    end
  end
  mode_timing_a: assert property (since_rst == 4'h4 |-> HOST_MODE == 2'h0 ##4 HOST_MODE != 2'h0)
    else $error("mode timing");
  mode_decode_a: assert property ($past(HOST_MODE) == 2'h0 && HOST_MODE != 2'h0 |->
    HOST_MODE == (TWO_WIRE_SEL_PIN ? 2'h3 : {EXT_ADDR_SELECT_PIN, !EXT_ADDR_SELECT_PIN}))
    else $error("mode decode");
  mode_hold_a: assert property (HOST_MODE != 2'h0 |=> $stable(HOST_MODE))
    else $error("mode changed");
  wire_release_a: assert property (HOST_MODE == 2'h3 |-> !(D5_OE | D6_OE | D7_OE))
    else $error("two-wire pins driven");
  uart_pins_a: assert property (HOST_MODE == 2'h1 |-> D7_OE && D5_OE == D6_OE)
    else $error("uart enables");
  miso_release_a: assert property ((HOST_MODE == 2'h2 && SPI_SELECT_N) [*4] |-> !D7_OE)
    else $error("miso driven unselected");
  miso_edge_a: assert property (HOST_MODE == 2'h2 && !SPI_SELECT_N && $changed(D7_OUT) |-> !D5_IN)
    else $error("miso changed with clock high");
  wr_hold_a: assert property (REG_WR_VALID && !REG_WR_READY |=>
    REG_WR_VALID && $stable({REG_WR_ADDR, REG_WR_DATA}))
    else $error("write request dropped");
endmodule : hsi_top_asserts
bind hsi_top hsi_top_asserts chk (.*);

// *** hsi_host_model.sv ***
// Purpose: host master model on the SPI pins and on the UART lines
// Assumes: called just after a clk edge
// Notes: SCK stands low outside frames
`timescale 1ns/1ps
module hsi_host_model (
  input wire logic clk,
  output logic sck,
  output logic mosi,
  output logic sel_n,
  input wire logic miso
);
  // ------
  // master
  // ------
  // default 9.6 kBd against the 50 ns bench clock
  localparam int UART_BIT = 20000000 / 9600;
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    sel_n = 1'b1;
  end
  task automatic frame(input logic active);
    if (!active) begin
      sck <= 1'b0;
      repeat (6) @(posedge clk);
      mosi <= !mosi; // released line not left at last bit
    end
    sel_n <= !active;
    repeat (6) @(posedge clk);
  endtask : frame
  // master makes the clock, slave only answers
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      mosi <= tx[i];
      repeat (6) @(posedge clk);
      sck <= 1'b1;
      rx[i] = miso;
      repeat (6) @(posedge clk);
    end
  endtask : xfer
  // select pin doubles as the receive line in uart mode
  task automatic uart_read(input logic [7:0] a, output logic [8:0] rx);
    logic [8:0] f;
    f = {a, 1'b0};
    for (int i = 0; i < 9; i++) begin
      sel_n <= f[i]; // start bit, then lsb first
      repeat (UART_BIT) @(posedge clk);
    end
    sel_n <= 1'b1; // stop bit stays while the answer comes
    @(negedge miso);
    repeat (UART_BIT / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (UART_BIT) @(posedge clk);
      rx[i] = miso;
    end
  endtask : uart_read
endmodule : hsi_host_model

// *** hsi_top_bench.sv ***
// Purpose: self-checking bench of hsi_top
// Assumes: register side modelled here, SPI host in hsi_host_model
// Notes: two-wire run checks mode only; UART run does one read at the default rate
`timescale 1ns/1ps
module hsi_top_bench
  import hsi_pkg::*;
;
  // ------
  // bench
  // ------
  logic clk, rst_n, two_wire, ext_addr, wr_ready, hold;
  logic sck, mosi, sel_n, d7_out, d7_oe, wr_valid, overrun;
  logic d5_out, d6_out, rd_strobe;
  logic [1:0] mode;
  logic [5:0] rd_addr, wr_addr, ua;
  logic [7:0] wr_data, rx, lfsr;
  logic [8:0] urx;
  logic [13:0] exp_wr[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_rd = 0;
  function automatic logic [7:0] reg_val(input logic [5:0] a);
    return {a, 2'h1} ^ 8'hA5;
  endfunction : reg_val
  function automatic logic [7:0] next_rnd(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : next_rnd
  hsi_host_model host (.clk(clk), .sck(sck), .mosi(mosi), .sel_n(sel_n),
    .miso(d7_oe ? d7_out : 1'bz));
  hsi_top uut (
    .CLK_SYS(clk),
    .RST_N(rst_n),
    .TWO_WIRE_SEL_PIN(two_wire),
    .EXT_ADDR_SELECT_PIN(ext_addr),
    .SPI_SELECT_N(sel_n),
    .D5_IN(sck),
    .D5_OUT(d5_out),
    .D5_OE(),
    .D6_IN(mosi),
    .D6_OUT(d6_out),
    .D6_OE(),
    .D7_IN(d7_oe ? d7_out : 1'b1),
    .D7_OUT(d7_out),
    .D7_OE(d7_oe),
    .HOST_MODE(mode),
    .REG_RD_STROBE(rd_strobe),
    .REG_RD_ADDR(rd_addr),
    .REG_RD_DATA(reg_val(rd_addr)),
    .REG_WR_VALID(wr_valid),
    .REG_WR_READY(wr_ready),
    .REG_WR_ADDR(wr_addr),
    .REG_WR_DATA(wr_data),
    .WR_OVERRUN(overrun)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // random stalls on the register write port
  always @(posedge clk) begin
    lfsr <= next_rnd(lfsr);
    wr_ready <= !hold && lfsr[0];
  end
  task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  always @(posedge clk) begin
    if (rd_strobe === 1'b1) begin
      n_rd++;
    end
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      check("write", exp_wr.size() ? exp_wr.pop_front() : 14'bx, {wr_addr, wr_data});
    end
  end
  task automatic do_reset(input logic tw, input logic ea);
    rst_n <= 1'b0;
    two_wire <= tw;
    ext_addr <= ea;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    check("mode", {12'h0, tw ? 2'h3 : {ea, !ea}}, {12'h0, mode});
  endtask : do_reset
  // only the first nine bytes fit while stalled: fifo plus output stage
  task automatic spi_write(input logic [5:0] a, input int n, input logic [7:0] d0);
    logic [7:0] d;
    host.frame(1'b1);
    host.xfer({1'b0, a, 1'b0}, rx);
    for (int k = 0; k < n; k++) begin
      d = k ? lfsr : d0;
      if (!hold || k < 9) exp_wr.push_back({a, d});
      host.xfer(d, rx);
    end
    host.frame(1'b0);
  endtask : spi_write
  task automatic spi_read(input logic [5:0] a1, input logic [5:0] a2, input logic [7:0] e1);
    host.frame(1'b1);
    host.xfer({1'b1, a1, 1'b0}, rx);
    host.xfer({1'b1, a2, 1'b0}, rx);
    check("read first", {6'h0, e1}, {6'h0, rx});
    host.xfer(SPI_END_BYTE, rx);
    check("read last", {6'h0, reg_val(a2)}, {6'h0, rx});
    host.frame(1'b0);
  endtask : spi_read
  initial begin
    lfsr = 8'h17;
    hold = 1'b0;
    wr_ready = 1'b0;
    do_reset(1'b1, 1'b0);
    do_reset(1'b0, 1'b0);
    do_reset(1'b0, 1'b1);
    two_wire <= 1'b1;
    ext_addr <= 1'b0;
    $display("test mode select done");
    spi_write(6'h05, 3, lfsr);
    spi_read(SPEED_ADDR, {2'h0, lfsr[3:0]}, SPEED_RESET);
    $display("test burst access done");
    spi_write(SPEED_ADDR, 1, 8'h15); // fastest legal rate
    spi_read(SPEED_ADDR, 6'h2A, 8'h15);
    $display("test speed register done");
    repeat (40) @(posedge clk);
    hold <= 1'b1;
    spi_write(6'h0A, 10, lfsr);
    check("overrun", 14'h1, {13'h0, overrun});
    hold <= 1'b0;
    repeat (80) @(posedge clk);
    check("writes left", 14'h0, 14'(exp_wr.size()));
    $display("test fifo overrun done");
    do_reset(1'b0, 1'b0);
    ua = {2'h0, lfsr[3:0]};
    host.uart_read({1'b1, lfsr[4], ua}, urx); // reserved bit random
    check("uart read", {6'h0, reg_val(ua)}, {6'h0, urx[7:0]});
    check("uart stop", 14'h1, {13'h0, urx[8]});
    check("uart request", 14'h1, {13'h0, d5_out});
    check("uart aux", 14'h1, {13'h0, d6_out});
    check("read strobes", 14'h5, 14'(n_rd)); // end byte issues no read
    $display("test uart read done");
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    two_wire = 1'b0;
    ext_addr = 1'b0;
    // two uart characters at 9.6 kBd take about 42000 cycles
    repeat (60000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
endmodule : hsi_top_bench
